// ### ppc_pkg.sv
// shared constants for the parallel port and divided clock output block
package ppc_pkg;

	// ==========================================================
	// port numbering as seen on the select inputs
	localparam logic [3:0] PORT_BUS_MUX   = 4'h0;  // bus_multiplex_port
	localparam logic [3:0] PORT_ONE       = 4'h1;
	localparam logic [3:0] PORT_HIGH_ADDR = 4'h2;  // high_address_port
	localparam logic [3:0] PORT_ANALOG_A  = 4'h7;  // analog_input_port_a
	localparam logic [3:0] PORT_ANALOG_B  = 4'h8;  // analog_input_port_b
	localparam logic [3:0] PORT_NINE      = 4'h9;

	// ==========================================================
	// array geometry and reset values
	localparam int         NUM_DIG_PORTS  = 8;      // ports 0..6 and 9
	localparam int         IDX_NINE       = 7;      // array slot of port 9
	localparam logic [7:0] LATCH_RESET    = 8'hFF;  // all latches high after reset
	localparam logic [7:0] DIR_RESET      = 8'hFF;  // all lines inputs after reset
	localparam int         CLK_OUT_BIT    = 6;      // port_one_bit_six
	localparam int         CLK_ENABLE_BIT = 6;      // enable bit in converter_control_reg0

	// ==========================================================
	// divided clock output: periods and half periods in oscillator cycles
	localparam int         OSC_PER_CLK_FAST = 6;   // prescale clear: fosc/6
	localparam int         OSC_PER_CLK_SLOW = 12;  // prescale set: fosc/12
	localparam int         SLOW_DOWN_FACTOR = 8;
	localparam logic [6:0] HALF_FAST = 7'(OSC_PER_CLK_FAST / 2);
	localparam logic [6:0] HALF_SLOW = 7'(OSC_PER_CLK_SLOW / 2);
	localparam logic [6:0] HALF_FAST_SD = 7'(OSC_PER_CLK_FAST * SLOW_DOWN_FACTOR / 2);
	localparam logic [6:0] HALF_SLOW_SD = 7'(OSC_PER_CLK_SLOW * SLOW_DOWN_FACTOR / 2);
	localparam logic       PRESCALE_RESET = 1'b1;  // divide by twelve out of reset

endpackage

// ### ppc_parallel_port.sv
// parallel i/o ports, external bus multiplexing and divided clock output
//
// Functional notes
// - sixty-four lines as eight 8-bit ports
// - each bit: latch, driver, input buffer
// - one mode bit selects quasi or bidirectional
// - bus port carries low address then data
// - high address only when address 16 bits
// - analog ports input-only, writes ignored
// - analog ports read byte-wide together
// - latch captures internal bus on write strobe
// - latch read returns stored latch value
// - pin read returns sensed line level
// - instruction chooses latch or pin read
// - enable bit drives divided clock on pin while its latch bit is one
// - prescale clear /6, set /12, reset /12
// - slow-down divides clock output by eight
// - reset sets latches of ports 0-6 high
// - reset selects quasi-bidirectional structure
// - direction zero output, one input, reset ones
`timescale 1ns/1ps

module ppc_parallel_port (
	input  wire logic                  i_clock,
	input  wire logic                  i_rst,
	// internal bus access
	input  wire logic                  i_wr_strobe,          // write-to-latch pulse
	input  wire logic [3:0]            i_wr_port,
	input  wire logic [7:0]            i_wr_data,
	input  wire logic                  i_dir_access,         // target direction registers
	input  wire logic                  i_rd_strobe,
	input  wire logic [3:0]            i_rd_port,
	input  wire logic                  i_rd_from_latch,      // 1 latch path, 0 pin path
	output logic      [7:0]            o_rd_data,
	output logic                       o_rd_valid,
	// control bits
	input  wire logic                  i_port_style_select,  // 0 quasi, 1 bidirectional
	input  wire logic                  i_clock_out_prescale, // 0 /6, 1 /12
	input  wire logic [7:0]            i_converter_control_reg0,
	input  wire logic                  i_slow_down,
	// external memory bus
	input  wire logic                  i_ext_active,
	input  wire logic                  i_ext_addr_phase,
	input  wire logic                  i_ext_wide_addr,
	input  wire logic                  i_ext_write,
	input  wire logic [15:0]           i_ext_addr,
	input  wire logic [7:0]            i_ext_wdata,
	output logic      [7:0]            o_ext_rdata,
	// pins: slot 0..6 are ports 0..6, slot 7 is port 9
	input  wire logic [7:0][7:0]       i_pin_in,
	output logic      [7:0][7:0]       o_pin_out,
	output logic      [7:0][7:0]       o_pin_oe,
	input  wire logic [7:0]            i_analog_a_in,
	input  wire logic [7:0]            i_analog_b_in
);

	// ==========================================================
	// storage
	logic [7:0][7:0] latch_reg;   // port bit latches
	logic [7:0][7:0] dir_reg;     // direction registers
	logic [7:0][7:0] pin_s1_reg;  // first synchroniser stage
	logic [7:0][7:0] pin_reg;     // synchronised pin levels
	logic [7:0]      ana_a_s1_reg;
	logic [7:0]      ana_a_reg;
	logic [7:0]      ana_b_s1_reg;
	logic [7:0]      ana_b_reg;
	logic [6:0]      div_cnt_reg; // divided clock half-period counter
	logic            clk_div_reg; // divided clock level
	logic [6:0]      half_next;   // current half-period length

	// maps a port number to its array slot; analog and unused give none
	function automatic logic [3:0] slot_of(input logic [3:0] port);
		logic [3:0] s;
		s = 4'hF;
		if (port <= 4'h6)
			s = port;
		else if (port == ppc_pkg::PORT_NINE)
			s = 4'(ppc_pkg::IDX_NINE);
		return s;
	endfunction

	logic [3:0] wr_slot;
	logic [3:0] rd_slot;
	assign wr_slot = slot_of(i_wr_port);
	assign rd_slot = slot_of(i_rd_port);

	// ==========================================================
	// input synchronisers: pins are foreign to the clock
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pin_s1_reg   <= '0;
			pin_reg      <= '0;
			ana_a_s1_reg <= 8'h00;
			ana_a_reg    <= 8'h00;
			ana_b_s1_reg <= 8'h00;
			ana_b_reg    <= 8'h00;
		end else begin
			pin_s1_reg   <= i_pin_in;
			pin_reg      <= pin_s1_reg;
			ana_a_s1_reg <= i_analog_a_in;
			ana_a_reg    <= ana_a_s1_reg;
			ana_b_s1_reg <= i_analog_b_in;
			ana_b_reg    <= ana_b_s1_reg;
		end
	end

	// ==========================================================
	// latches and direction registers, one slot per digital port
	genvar g;
	generate
		for (g = 0; g < ppc_pkg::NUM_DIG_PORTS; g++) begin : g_port
			// write strobe clocks the internal bus into the chosen register
			always_ff @(posedge i_clock or posedge i_rst) begin
				if (i_rst) begin
					latch_reg[g] <= ppc_pkg::LATCH_RESET;
					dir_reg[g]   <= ppc_pkg::DIR_RESET;
				end else if (i_wr_strobe && wr_slot == 4'(g)) begin
					// analog ports never match a slot, so their writes vanish
					if (i_dir_access)
						dir_reg[g]   <= i_wr_data;
					else
						latch_reg[g] <= i_wr_data;
				end
			end
		end
	endgenerate

	// ==========================================================
	// divided clock generator; runs always so the pin phase is steady
	always_comb begin
		if (i_slow_down)
			half_next = i_clock_out_prescale ? ppc_pkg::HALF_SLOW_SD : ppc_pkg::HALF_FAST_SD;
		else
			half_next = i_clock_out_prescale ? ppc_pkg::HALF_SLOW : ppc_pkg::HALF_FAST;
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			div_cnt_reg <= 7'h00;
			clk_div_reg <= 1'b0;
		end else if (div_cnt_reg >= half_next - 7'h01) begin
			// toggle at each half period
			div_cnt_reg <= 7'h00;
			clk_div_reg <= ~clk_div_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 7'h01;
		end
	end

	// ==========================================================
	// pin drivers; registered so outputs come from flip-flops
	logic clk_out_en;
	assign clk_out_en = i_converter_control_reg0[ppc_pkg::CLK_ENABLE_BIT];

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_pin_out <= '0;
			o_pin_oe  <= '0;   // quasi mode with latches high: nothing pulls low
		end else begin
			for (int p = 0; p < ppc_pkg::NUM_DIG_PORTS; p++) begin
				if (i_port_style_select) begin
					// bidirectional: direction zero drives the latch
					o_pin_out[p] <= latch_reg[p];
					o_pin_oe[p]  <= ~dir_reg[p];
				end else begin
					// quasi: only a zero is driven hard, a one is left to pull-ups
					o_pin_out[p] <= 8'h00;
					o_pin_oe[p]  <= ~latch_reg[p];
				end
			end
			// alternate clock function gated by the latch bit
			if (clk_out_en) begin
				o_pin_out[ppc_pkg::PORT_ONE][ppc_pkg::CLK_OUT_BIT] <=
					latch_reg[ppc_pkg::PORT_ONE][ppc_pkg::CLK_OUT_BIT] & clk_div_reg;
				o_pin_oe[ppc_pkg::PORT_ONE][ppc_pkg::CLK_OUT_BIT]  <=
					latch_reg[ppc_pkg::PORT_ONE][ppc_pkg::CLK_OUT_BIT];
			end
			// external bus overrides port 0: address then data
			if (i_ext_active) begin
				o_pin_out[ppc_pkg::PORT_BUS_MUX] <= i_ext_addr_phase ? i_ext_addr[7:0]
					: i_ext_wdata;
				o_pin_oe[ppc_pkg::PORT_BUS_MUX]  <= {8{i_ext_addr_phase | i_ext_write}};
			end
			// high byte only for wide addresses, else latch contents stay
			if (i_ext_active && i_ext_wide_addr) begin
				o_pin_out[ppc_pkg::PORT_HIGH_ADDR] <= i_ext_addr[15:8];
				o_pin_oe[ppc_pkg::PORT_HIGH_ADDR]  <= 8'hFF;
			end
		end
	end

	// ==========================================================
	// read path: latch or pin chosen per access, analog byte-wide
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data  <= 8'h00;
			o_rd_valid <= 1'b0;
			o_ext_rdata <= 8'h00;
		end else begin
			o_rd_valid  <= i_rd_strobe;
			o_ext_rdata <= pin_reg[ppc_pkg::PORT_BUS_MUX];
			if (i_rd_strobe) begin
				if (i_rd_port == ppc_pkg::PORT_ANALOG_A)
					o_rd_data <= ana_a_reg;
				else if (i_rd_port == ppc_pkg::PORT_ANALOG_B)
					o_rd_data <= ana_b_reg;
				else if (rd_slot == 4'hF)
					o_rd_data <= 8'h00;
				else if (i_dir_access)
					o_rd_data <= dir_reg[rd_slot[2:0]];
				else if (i_rd_from_latch)
					o_rd_data <= latch_reg[rd_slot[2:0]];
				else
					o_rd_data <= pin_reg[rd_slot[2:0]];
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	AST_LATCH_WRITE: assert property (
		(i_wr_strobe && !i_dir_access && i_wr_port == ppc_pkg::PORT_ONE)
		|=> latch_reg[1] == $past(i_wr_data))
		else $error("latch did not capture written byte");
	AST_ANALOG_WRITE_IGNORED: assert property (
		(i_wr_strobe && i_wr_port == ppc_pkg::PORT_ANALOG_A) |=> $stable(latch_reg))
		else $error("write to analog port changed a latch");
	AST_READ_LATCH: assert property (
		(i_rd_strobe && i_rd_from_latch && !i_dir_access && !i_wr_strobe
			&& i_rd_port == ppc_pkg::PORT_HIGH_ADDR)
		|=> o_rd_valid && o_rd_data == latch_reg[2])
		else $error("latch read returned wrong value");
	AST_READ_PIN: assert property (
		(i_rd_strobe && !i_rd_from_latch && !i_dir_access && i_rd_port == ppc_pkg::PORT_ONE)
		|=> o_rd_data == $past(pin_reg[1]))
		else $error("pin read returned wrong value");
	AST_ANALOG_READ: assert property (
		(i_rd_strobe && i_rd_port == ppc_pkg::PORT_ANALOG_B) |=> o_rd_data == $past(ana_b_reg))
		else $error("analog port read wrong");
	// a toggle seen at t means the counter restarted one edge earlier, so in /6 mode
	// the next toggle must be seen exactly three edges later if the mode holds meanwhile
	AST_CLOCK_TOGGLES: assert property (
		(!i_slow_down && !i_clock_out_prescale && $changed(clk_div_reg))
		##1 (!i_slow_down && !i_clock_out_prescale) [*2]
		|=> $changed(clk_div_reg))
		else $error("fast clock output half period wrong");
	AST_CLOCK_GATED: assert property (
		(!clk_out_en && !i_port_style_select && !i_ext_active)
		|=> o_pin_oe[1][6] == !$past(latch_reg[1][6]))
		else $error("clock pin driven while disabled");
	AST_HIGH_ADDR: assert property (
		(i_ext_active && i_ext_wide_addr) |=> o_pin_out[2] == $past(i_ext_addr[15:8])
		&& o_pin_oe[2] == 8'hFF)
		else $error("high address byte not driven");
	AST_BUS_ADDR: assert property (
		(i_ext_active && i_ext_addr_phase) |=> o_pin_out[0] == $past(i_ext_addr[7:0]))
		else $error("low address not driven on bus port");
	AST_BIDIR_DIR: assert property (
		(i_port_style_select && !clk_out_en && !i_ext_active)
		|=> o_pin_oe[3] == ~$past(dir_reg[3]))
		else $error("direction bit did not set driver");

endmodule

// ### ppc_pin_model.sv
// pin-side partner model: pull-ups and peripherals on the port lines
`timescale 1ns/1ps

module ppc_pin_model (
	input  wire logic            i_clock,
	input  wire logic [7:0][7:0] i_pin_out,
	input  wire logic [7:0][7:0] i_pin_oe,
	input  wire logic [7:0][7:0] i_ext_en,   // peripheral drives the line
	input  wire logic [7:0][7:0] i_ext_val,  // level the peripheral drives
	output logic      [7:0][7:0] o_level     // resolved line level
);
	// ==========================================================
	// line resolution
	logic [7:0] float_pat;  // port 0 has no pull-up, so a released line wanders
	initial float_pat = 8'h55;
	always @(posedge i_clock) float_pat <= ~float_pat;
	// design wins a contention; a peripheral must not fight a driven pin
	always_comb begin
		for (int s = 0; s < 8; s++) begin
			for (int b = 0; b < 8; b++) begin
				if (i_pin_oe[s][b]) o_level[s][b] = i_pin_out[s][b];
				else if (i_ext_en[s][b]) o_level[s][b] = i_ext_val[s][b];
				else o_level[s][b] = (s == 0) ? float_pat[b] : 1'b1;
			end
		end
	end
endmodule

// ### ppc_tb.sv
// self-checking testbench for the parallel port block
`timescale 1ns/1ps

module tb;
	// ==========================================================
	// stimulus and observation signals, named as the ports
	logic i_clock, i_rst, i_wr_strobe, i_dir_access, i_rd_strobe, i_rd_from_latch;
	logic i_port_style_select, i_clock_out_prescale, i_slow_down, o_rd_valid;
	logic i_ext_active, i_ext_addr_phase, i_ext_wide_addr, i_ext_write;
	logic [3:0] i_wr_port, i_rd_port;
	logic [7:0] i_wr_data, o_rd_data, i_converter_control_reg0, i_ext_wdata, o_ext_rdata, d;
	logic [7:0] i_analog_a_in, i_analog_b_in;
	logic [15:0] i_ext_addr;
	logic [7:0][7:0] i_pin_in, o_pin_out, o_pin_oe, ext_en, ext_val;
	logic [3:0] dig [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
	int failures, checks_done, cycles, n;

	ppc_parallel_port dut (.i_clock, .i_rst, .i_wr_strobe, .i_wr_port, .i_wr_data,
		.i_dir_access, .i_rd_strobe, .i_rd_port, .i_rd_from_latch, .o_rd_data, .o_rd_valid,
		.i_port_style_select, .i_clock_out_prescale, .i_converter_control_reg0, .i_slow_down,
		.i_ext_active, .i_ext_addr_phase, .i_ext_wide_addr, .i_ext_write, .i_ext_addr,
		.i_ext_wdata, .o_ext_rdata, .i_pin_in, .o_pin_out, .o_pin_oe, .i_analog_a_in,
		.i_analog_b_in);
	ppc_pin_model pins (.i_clock, .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
		.i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pin_in));

	// ==========================================================
	// clock and hang guard
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// ==========================================================
	// shared helpers
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_byte(input logic [3:0] p, input logic [7:0] v, input logic to_dir);
		@(negedge i_clock);
		{i_wr_strobe, i_wr_port, i_wr_data, i_dir_access} = {1'b1, p, v, to_dir};
		@(negedge i_clock);
		{i_wr_strobe, i_dir_access} = 2'b00;
		repeat (6) @(negedge i_clock);  // covers pin register plus 2-flop sync
	endtask
	task automatic rd_byte(input logic [3:0] p, input logic latch, input logic from_dir);
		@(negedge i_clock);
		{i_rd_strobe, i_rd_port, i_rd_from_latch, i_dir_access} = {1'b1, p, latch, from_dir};
		@(negedge i_clock);
		i_rd_strobe = 1'b0;
		n = 0;
		while (o_rd_valid !== 1'b1 && n < 4) begin
			@(negedge i_clock);
			n++;
		end
		d = o_rd_data;
		i_dir_access = 1'b0;
		check("read valid", o_rd_valid, 1);
	endtask
	task automatic wait_rise();  // cycles to next rising edge of the clock pin
		logic last;
		n = 0;
		do begin
			last = o_pin_out[1][6];
			@(negedge i_clock);
			n++;
		end while (!(last === 1'b0 && o_pin_out[1][6] === 1'b1) && n < 300);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		check("quasi oe p1", o_pin_oe[1], 8'h00);
		foreach (dig[i]) begin
			rd_byte(dig[i], 1'b1, 1'b0);
			check("latch reset", d, 8'hFF);
			rd_byte(dig[i], 1'b1, 1'b1);
			check("dir reset", d, 8'hFF);
		end
		$display("test reset done");
	endtask
	task automatic t_latch_pin();
		wr_byte(4'h3, 8'hA5, 1'b0);
		rd_byte(4'h3, 1'b1, 1'b0);
		check("latch read", d, 8'hA5);
		rd_byte(4'h3, 1'b0, 1'b0);
		check("pin read", d, 8'hA5);
		rd_byte(4'h1, 1'b0, 1'b0);
		check("pin read port one", d, 8'hFF);
		ext_en[3] = 8'hFF;  // peripheral pulls every line low
		ext_val[3] = 8'h00;
		repeat (4) @(negedge i_clock);
		rd_byte(4'h3, 1'b0, 1'b0);
		check("pin pulled", d, 8'h00);
		rd_byte(4'h3, 1'b1, 1'b0);
		check("latch kept", d, 8'hA5);
		ext_en[3] = 8'h00;
		$display("test latch_pin done");
	endtask
	task automatic t_analog();
		wr_byte(4'h7, 8'h00, 1'b0);
		rd_byte(4'h7, 1'b1, 1'b0);
		check("analog a", d, 8'h3C);
		i_analog_b_in = 8'h96;
		repeat (4) @(negedge i_clock);
		rd_byte(4'h8, 1'b0, 1'b0);
		check("analog b", d, 8'h96);
		$display("test analog done");
	endtask
	task automatic t_bidir();
		i_port_style_select = 1'b1;
		wr_byte(4'h4, 8'h0F, 1'b1);
		wr_byte(4'h4, 8'h5A, 1'b0);
		check("bidir oe", o_pin_oe[4], 8'hF0);
		check("bidir out", o_pin_out[4] & 8'hF0, 8'h50);
		i_port_style_select = 1'b0;
		repeat (3) @(negedge i_clock);
		check("quasi oe", o_pin_oe[4], 8'hA5);
		$display("test bidir done");
	endtask
	task automatic t_ext();
		wr_byte(4'h2, 8'h0F, 1'b0);
		{i_ext_active, i_ext_addr_phase, i_ext_wide_addr, i_ext_addr} = {3'b111, 16'h1234};
		repeat (2) @(negedge i_clock);
		check("addr low", {o_pin_oe[0], o_pin_out[0]}, 16'hFF34);
		check("addr high", {o_pin_oe[2], o_pin_out[2]}, 16'hFF12);
		{i_ext_addr_phase, i_ext_write, i_ext_wdata} = {2'b01, 8'hC3};
		repeat (2) @(negedge i_clock);
		check("wdata", {o_pin_oe[0], o_pin_out[0]}, 16'hFFC3);
		{i_ext_write, i_ext_wide_addr, ext_en[0], ext_val[0]} = {2'b00, 8'hFF, 8'h5A};
		repeat (5) @(negedge i_clock);
		check("rd oe", o_pin_oe[0], 8'h00);
		check("rdata", o_ext_rdata, 8'h5A);
		check("narrow high port", o_pin_oe[2], 8'hF0);
		{i_ext_active, ext_en[0]} = 9'h000;
		$display("test ext done");
	endtask
	task automatic t_clock();
		i_converter_control_reg0 = 8'h40;  // latch of the pin left at one
		for (int k = 0; k < 4; k++) begin
			{i_slow_down, i_clock_out_prescale} = k[1:0];
			repeat (2) wait_rise();
			wait_rise();
			check("clk period", n, (k[0] ? 12 : 6) * (k[1] ? 8 : 1));
			check("clk oe", o_pin_oe[1][6], 1);
		end
		wr_byte(4'h1, 8'hBF, 1'b0);
		wait_rise();
		check("gated clk", {o_pin_out[1][6], n[8:0]}, 16'd300);
		$display("test clock done");
	endtask

	// ==========================================================
	// verdict
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		{i_rst, i_wr_strobe, i_dir_access, i_rd_strobe, i_rd_from_latch} = 5'b10000;
		{i_port_style_select, i_clock_out_prescale, i_slow_down} = 3'b010;
		{i_ext_active, i_ext_addr_phase, i_ext_wide_addr, i_ext_write} = 4'h0;
		{i_wr_port, i_rd_port, i_wr_data, i_ext_wdata, i_ext_addr} = 40'h0;
		{i_converter_control_reg0, i_analog_a_in, i_analog_b_in} = {16'h003C, 8'hC6};
		{ext_en, ext_val} = '0;
		repeat (4) @(negedge i_clock);
		i_rst = 1'b0;
		@(negedge i_clock);
		t_reset();
		t_latch_pin();
		t_analog();
		t_bidir();
		t_ext();
		t_clock();
		report_and_stop();
	end
endmodule
